// ### bench/trap_and_irq_vector_map_tb.sv
// Self-checking bench for the trap and request vector selector.
// Assumes the core model and checker files compile before it.
`timescale 1ns/1ps
module trap_and_irq_vector_map_tb;
	import trap_irq_pkg::*;
	localparam logic [TADDR_W-1:0] BB = 24'h002000;
	typedef struct packed {logic [5:0] n; logic [2:0] p; logic [VEC_W-1:0] v;} row_t;
	row_t rows [6] = '{'{0, 1, 8}, '{3, 7, 11}, '{4, 2, 12}, '{20, 4, 28}, '{33, 6, 41}, '{37, 3, 45}};
	logic [DATA_W-1:0] st [5] = '{16'h0002, 16'h0008, 16'h0002, 16'h0008, 16'h0008};
	logic clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, irq;
	logic [NUM_REQ-1:0] req = '0;
	logic [4:0] tr = '0;
	logic [ADDR_W-1:0] a = '0;
	logic [DATA_W-1:0] wd = '0, rdata;
	logic [VEC_W-1:0] vec, tvec;
	logic [PRIO_W-1:0] lvl;
	logic [TADDR_W-1:0] ta;
	int bad_count = 0, check_count = 0, n;
	always #4 clk = ~clk;
	trap_and_irq_vector_map #(.BOOT_BASE(BB)) uut (.ref_clk_in(clk), .rst_in(rst), .req_in(req),
		.osc_fail_in(tr[0]), .addr_error_in(tr[1]), .ecc_double_error_in(tr[2]), .stack_error_in(tr[3]),
		.divide_zero_error_in(tr[4]), .ctl_sel_in(sel), .addr_in(a), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .irq_out(irq), .vector_out(vec), .level_out(lvl), .table_addr_out(ta));
	vector_core_model core (.ref_clk_in(clk), .rst_in(rst), .irq_in(irq), .vector_in(vec), .taken_vec_out(tvec));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic s, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		@(posedge clk);
		{sel, a, wd, wr} <= {s, ad, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic s, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
		@(posedge clk);
		{sel, a, rd} <= {s, ad, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(32'(rdata), 32'(e));
	endtask
	task automatic fire(input logic [NUM_REQ-1:0] r, input logic [4:0] t);
		@(posedge clk);
		{req, tr} <= {r, t};
		@(posedge clk);
		{req, tr} <= '0;
		tick();
	endtask
	task automatic see(input logic i, input logic [VEC_W-1:0] v, input logic [PRIO_W-1:0] l, input logic [TADDR_W-1:0] t);
		chk(32'(irq), 32'(i));
		chk(32'(vec), 32'(v));
		if (i) begin
			chk(32'(lvl), 32'(l));
			chk(32'(ta), 32'(t));
		end
	endtask
	task automatic clr();
		for (int k = 0; k < 3; k++) begin
			wreg(1'b0, ADDR_W'(k), '0);
			wreg(1'b1, ADDR_W'(k), '0);
		end
		tick();
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			n = rows[i].n;
			wreg(1'b0, ADDR_W'(3 + n / 16), DATA_W'(1) << (n % 16));
			wreg(1'b0, ADDR_W'(6 + n / 4), DATA_W'(rows[i].p) << (4 * (n % 4)));
			fire(NUM_REQ'(1) << n, 5'h00);
			see(1'b1, rows[i].v, PRIO_W'(rows[i].p), TADDR_W'(20 + 2 * n));
			rreg(1'b0, ADDR_W'(n / 16), DATA_W'(1) << (n % 16));
			rreg(1'b0, ADDR_W'(6 + n / 4), DATA_W'(rows[i].p) << (4 * (n % 4)));
			wreg(1'b0, ADDR_W'((tvec - 8) / 16), '0);
			tick();
			see(1'b0, '0, '0, '0);
		end
		wreg(1'b0, REG_ENABLE0, 16'h000a);
		wreg(1'b0, REG_PRIO0, 16'h5050);
		fire(40'h0a, 5'h00);
		see(1'b1, 7'd9, 4'd5, 24'h000016);
		wreg(1'b0, REG_PRIO0, 16'h5010);
		tick();
		see(1'b1, 7'd11, 4'd5, 24'h00001a);
		wreg(1'b0, REG_PRIO0, 16'h0010);
		tick();
		see(1'b1, 7'd9, 4'd1, 24'h000016);
		wreg(1'b0, REG_PRIO0, 16'h0000);
		tick();
		see(1'b0, '0, '0, '0);
		clr();
		wreg(1'b0, REG_ENABLE1, 16'hffff);
		wreg(1'b0, ADDR_W'(11), 16'h7777);
		fire(40'he0_0000, 5'h00);
		see(1'b0, '0, '0, '0);
		rreg(1'b0, REG_FLAG1, 16'h0000);
		rreg(1'b0, ADDR_W'(11), 16'h0007);
		rreg(1'b0, REG_ENABLE1, 16'he31f);
		for (int i = 0; i < 5; i++) begin
			fire('0, 5'(1 << i));
			see(1'b1, VEC_W'(i), PRIO_W'(15 - i), TADDR_W'(4 + 2 * i));
			rreg(1'b1, (i == 2) ? REG_CTL_HWE : REG_CTL_TRAP, st[i]);
			clr();
		end
		wreg(1'b0, REG_ENABLE0, 16'h0008);
		wreg(1'b0, REG_PRIO0, 16'h7000);
		fire(40'h08, 5'h1a);
		see(1'b1, VEC_ADDR, PRI_ADDR, 24'h000006);
		wreg(1'b1, REG_CTL_TRAP, 16'h0000);
		tick();
		see(1'b1, 7'd11, 4'd7, 24'h00001a);
		clr();
		wreg(1'b1, REG_CTL_HWE, 16'h0001);
		tick();
		see(1'b0, '0, '0, '0);
		wreg(1'b1, REG_CTL_TWO, 16'h2000);
		tick();
		see(1'b1, VEC_HARD, PRI_HARD, 24'h000008);
		clr();
		wreg(1'b1, REG_CTL_TWO, 16'h0100);
		rreg(1'b1, REG_CTL_TWO, 16'h0100);
		fire(40'h08, 5'h10);
		see(1'b1, VEC_MATH, PRI_MATH, BB + 24'h00000c);
		wreg(1'b1, REG_CTL_TRAP, 16'h0000);
		tick();
		see(1'b1, 7'd11, 4'd7, BB + 24'h00001a);
		clr();
		fire('0, 5'h01);
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		see(1'b0, '0, '0, '0);
		rst <= 1'b0;
		tick();
		see(1'b0, '0, '0, '0);
		rreg(1'b1, REG_CTL_TRAP, 16'h0000);
		rreg(1'b0, REG_ENABLE0, 16'h0000);
		conclude();
	end
endmodule

// ### bench/trap_irq_vector_sva.sv
// Checker for the selected vector, level and table address.
// Assumes binding onto the selector top with its single clock.
`timescale 1ns/1ps
module trap_irq_vector_sva #(
	parameter logic [trap_irq_pkg::TADDR_W-1:0] BOOT_BASE = 24'h001000
) (
	input wire logic                                 ref_clk_in,
	input wire logic                                 rst_in,
	input wire logic                                 osc_fail_in,
	input wire logic                                 irq_out,
	input wire logic [trap_irq_pkg::VEC_W-1:0]       vector_out,
	input wire logic [trap_irq_pkg::PRIO_W-1:0]      level_out,
	input wire logic [trap_irq_pkg::TADDR_W-1:0]     table_addr_out
);
	import trap_irq_pkg::*;
	logic [TADDR_W-1:0] off_w;
	assign off_w = TADDR_W'(4) + TADDR_W'({vector_out, 1'b0});
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence osc_seen;
		$rose(osc_fail_in);
	endsequence
	sequence osc_shown;
		##2 (irq_out && vector_out == VEC_OSC && level_out == PRI_OSC);
	endsequence
	a_osc_first_shown: assert property (osc_seen |-> osc_shown) else $error("osc trap not shown");
	a_addr_trap_vec: assert property (irq_out && level_out == PRI_ADDR |-> vector_out == VEC_ADDR)
		else $error("address trap vector wrong");
	a_hard_trap_vec: assert property (irq_out && level_out == PRI_HARD |-> vector_out == VEC_HARD)
		else $error("hard trap vector wrong");
	a_stack_trap_vec: assert property (irq_out && level_out == PRI_STACK |-> vector_out == VEC_STACK)
		else $error("stack trap vector wrong");
	a_math_trap_vec: assert property (irq_out && level_out == PRI_MATH |-> vector_out == VEC_MATH)
		else $error("math trap vector wrong");
	a_no_reserved_trap: assert property (irq_out |-> !(vector_out inside {[5:7]}))
		else $error("reserved trap raised");
	a_table_addr_map: assert property (irq_out |-> table_addr_out == off_w || table_addr_out == BOOT_BASE + off_w)
		else $error("table address wrong");
	a_req_level_range: assert property (irq_out && vector_out >= REQ_VEC_OFFSET |-> level_out inside {[1:7]})
		else $error("request level out of range");
	a_idle_vec_zero: assert property (!irq_out |-> vector_out == '0)
		else $error("vector without request");
endmodule

bind trap_and_irq_vector_map trap_irq_vector_sva #(.BOOT_BASE(BOOT_BASE)) chk (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .osc_fail_in(osc_fail_in), .irq_out(irq_out),
	.vector_out(vector_out), .level_out(level_out), .table_addr_out(table_addr_out));

// ### bench/vector_core_model.sv
// Core-side model that takes the vector presented as the request rises.
// Assumes the selector's registered request and vector outputs.
`timescale 1ns/1ps
module vector_core_model (
	input  wire logic                           ref_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           irq_in,
	input  wire logic [trap_irq_pkg::VEC_W-1:0] vector_in,
	output logic      [trap_irq_pkg::VEC_W-1:0] taken_vec_out
);
	import trap_irq_pkg::*;
	logic seen_q;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_q <= 1'b0;
			taken_vec_out <= '0;
		end else begin
			seen_q <= irq_in;
			if (irq_in && !seen_q) begin
				taken_vec_out <= vector_in;
			end
		end
	end
endmodule

// ### hdl/trap_and_irq_vector_map.sv
// Trap and peripheral request vector selection with flag, enable and priority registers.
// Assumes request and trap inputs are one-cycle pulses synchronous to ref_clk_in.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Oscillator failure: vector 0, address 000004h, priority 15, status bit 1.
// R2: Address error: vector 1, address 000006h, priority 14, status bit 3.
// R3: Double-bit flash error sets source bit 1, raises vector 2, priority 13, ungated.
// R4: Software hard trap sets source bit 0; vector 2 only when enable bit 13 set.
// R5: Stack error: vector 3, address 00000Ah, priority 12.
// R6: Divide-by-zero raises math trap: vector 4, address 00000Ch, priority 11.
// R7: Trap vectors 5 to 7 are reserved and never raised.
// R8: Alternate table entries are boot page base plus the primary low offset.
// R9: Request n maps to vector n+8 at table address 000014h plus 2n.
// R10: Flag and enable for request n sit at bit n%16 of register n/16.
// R11: Priority field of request n is bits 4k+2..4k of register n/4.
// R12: Reserved requests have no flag, enable or priority and never signal.
// R13: Each source drives its own listed request number input line.
// R14: Equal priority ties go to the lower vector number.
// R15: Control two bit 8 selects the alternate table for all vectors.
// R16: Seven user priority levels; every trap outranks every request.
// R17: One request presented with highest-priority pending enabled request; priority 0 never wins.
// R18: Software clears a flag after service; a set flag stays pending.
module trap_and_irq_vector_map #(
	parameter logic [trap_irq_pkg::TADDR_W-1:0] BOOT_BASE = 24'h001000
) (
	input  wire logic                                 ref_clk_in,
	input  wire logic                                 rst_in,
	input  wire logic [trap_irq_pkg::NUM_REQ-1:0]     req_in,
	input  wire logic                                 osc_fail_in,
	input  wire logic                                 addr_error_in,
	input  wire logic                                 ecc_double_error_in,
	input  wire logic                                 stack_error_in,
	input  wire logic                                 divide_zero_error_in,
	input  wire logic                                 ctl_sel_in,
	input  wire logic [trap_irq_pkg::ADDR_W-1:0]      addr_in,
	input  wire logic [trap_irq_pkg::DATA_W-1:0]      wdata_in,
	input  wire logic                                 wr_in,
	input  wire logic                                 rd_in,
	output logic      [trap_irq_pkg::DATA_W-1:0]      rdata_out,
	output logic                                      irq_out,
	output logic      [trap_irq_pkg::VEC_W-1:0]       vector_out,
	output logic      [trap_irq_pkg::PRIO_W-1:0]      level_out,
	output logic      [trap_irq_pkg::TADDR_W-1:0]     table_addr_out
);
	import trap_irq_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_REQ-1:0]     flag;
		logic [NUM_REQ-1:0]     enable;
		logic [NUM_REQ*3-1:0]   prio;
		logic                   osc_fail;
		logic                   addr_err;
		logic                   stack_err;
		logic                   math_err;
		logic                   ecc_dbl;
		logic                   soft_hard;
		logic                   soft_hard_en;
		logic                   alt_table;
		logic [DATA_W-1:0]      rdata;
		logic                   irq;
		logic [VEC_W-1:0]       vector;
		logic [PRIO_W-1:0]      level;
		logic [TADDR_W-1:0]     taddr;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ----------------------------------------------------------------
	// Address decode and field helpers
	// ----------------------------------------------------------------
	// Word regions of the request page
	typedef enum logic [1:0] {
		REGION_FLAG   = 2'b00,
		REGION_ENABLE = 2'b01,
		REGION_PRIO   = 2'b10
	} region_t;

	// Sorts a request-page word index into flag, enable or priority words
	function automatic region_t region_of(input logic [ADDR_W-1:0] ad);
		region_t r;
		r = REGION_PRIO;
		if (ad <= REG_FLAG2) begin
			r = REGION_FLAG;
		end else if (ad <= REG_ENABLE2) begin
			r = REGION_ENABLE;
		end
		return r;
	endfunction

	// First request number held by a flag or enable word
	function automatic int first_req(input logic [ADDR_W-1:0] ad);
		int base;
		base = int'(ad) * DATA_W;
		if (region_of(ad) == REGION_ENABLE) begin
			base = int'(ad - REG_ENABLE0) * DATA_W;
		end
		return base;
	endfunction

	// Reads the 3-bit priority field of one request
	function automatic logic [2:0] prio_of(input logic [NUM_REQ*3-1:0] v, input int n);
		return v[n*3 +: 3];
	endfunction

	// Reads a 16-bit slice of a wide vector by word index
	function automatic logic [DATA_W-1:0] word_of(input logic [NUM_REQ*3-1:0] v, input int idx);
		logic [DATA_W-1:0] w;
		w = '0;
		for (int b = 0; b < DATA_W; b++) begin
			if (idx*DATA_W + b < NUM_REQ*3) begin
				w[b] = v[idx*DATA_W + b];
			end
		end
		return w;
	endfunction

	// Translates a vector number into a table address
	function automatic logic [TADDR_W-1:0] table_of(input logic [VEC_W-1:0] v, input logic alt);
		logic [TADDR_W-1:0] a;
		a = TABLE_TRAP_BASE + {16'h0000, v, 1'b0};                    // R1 R9
		if (alt) begin
			a = BOOT_BASE + ALT_LOW_BASE + {16'h0000, v, 1'b0};       // R8
		end
		return a;
	endfunction

	// ----------------------------------------------------------------
	// Per-request masks
	// ----------------------------------------------------------------
	logic [NUM_REQ*3-1:0] prio_keep;
	logic [2:0]           eff_prio [NUM_REQ];

	// Reserved requests keep no priority field
	// Effective level is zero unless the request is flagged and enabled
	for (genvar g = 0; g < NUM_REQ; g++) begin : g_req
		assign prio_keep[g*3 +: 3] = REQ_RESERVED[g] ? 3'h0 : 3'h7;                         // R12
		assign eff_prio[g]         = (s_q.flag[g] && s_q.enable[g]) ? prio_of(s_q.prio, g) : 3'h0; // R17 R18
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [NUM_REQ-1:0]   set_flag;
		logic [3:0]           widx;
		logic [5:0]           fbase;
		logic [2:0]           best_p;
		logic [5:0]           best_n;
		logic                 found;
		logic                 hard_pend;
		logic [DATA_W-1:0]    rd;
		// ------------------------------------------------------------
		// Defaults
		// ------------------------------------------------------------
		s_d = s_q;
		set_flag = req_in & ~REQ_RESERVED;                                // R12 R13
		widx = 4'h0;
		fbase = 6'h00;
		best_p = 3'h0;
		best_n = 6'h00;
		found = 1'b0;
		hard_pend = 1'b0;
		rd = RST_WORD;

		// ------------------------------------------------------------
		// Request-page writes; hardware set wins over software clear
		// ------------------------------------------------------------
		if (wr_in && !ctl_sel_in) begin
			if (region_of(addr_in) == REGION_FLAG) begin
				fbase = 6'(first_req(addr_in));                             // R10
				for (int b = 0; b < DATA_W; b++) begin
					if (int'(fbase) + b < NUM_REQ) begin
						s_d.flag[int'(fbase) + b] = wdata_in[b];              // R18
					end
				end
			end else if (region_of(addr_in) == REGION_ENABLE) begin
				fbase = 6'(first_req(addr_in));                             // R10
				for (int b = 0; b < DATA_W; b++) begin
					if (int'(fbase) + b < NUM_REQ) begin
						s_d.enable[int'(fbase) + b] = wdata_in[b];
					end
				end
			end else begin
				widx = addr_in - REG_PRIO0;
				for (int k = 0; k < 4; k++) begin
					if (int'(widx)*4 + k < NUM_REQ) begin
						s_d.prio[(int'(widx)*4 + k)*3 +: 3] = wdata_in[k*4 +: 3]; // R11 R16
					end
				end
			end
		end

		// ------------------------------------------------------------
		// Control-page writes
		// ------------------------------------------------------------
		if (wr_in && ctl_sel_in) begin
			unique case (addr_in)
				REG_CTL_TRAP: begin
					s_d.osc_fail  = wdata_in[OSC_FAIL_BIT];
					s_d.addr_err  = s_q.addr_err  & wdata_in[GEN_TRAP_BIT];
					s_d.stack_err = s_q.stack_err & wdata_in[GEN_TRAP_BIT];
					s_d.math_err  = s_q.math_err  & wdata_in[GEN_TRAP_BIT];
				end
				REG_CTL_TWO: begin
					s_d.alt_table    = wdata_in[ALT_TABLE_BIT];              // R15
					s_d.soft_hard_en = wdata_in[SOFT_HARD_EN];             // R4
				end
				REG_CTL_HWE: begin
					s_d.ecc_dbl   = wdata_in[ECC_DBL_BIT];
					s_d.soft_hard = wdata_in[SOFT_HARD_BIT];               // R4
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// Reserved masks
		// ------------------------------------------------------------
		s_d.flag = (s_d.flag | set_flag) & ~REQ_RESERVED;                  // R12 R18
		s_d.enable = s_d.enable & ~REQ_RESERVED;
		s_d.prio = s_d.prio & prio_keep;

		// ------------------------------------------------------------
		// Hardware events
		// ------------------------------------------------------------
		s_d.osc_fail  = s_d.osc_fail  | osc_fail_in;                      // R1
		s_d.addr_err  = s_d.addr_err  | addr_error_in;                    // R2
		s_d.stack_err = s_d.stack_err | stack_error_in;                   // R5
		s_d.math_err  = s_d.math_err  | divide_zero_error_in;             // R6
		s_d.ecc_dbl   = s_d.ecc_dbl   | ecc_double_error_in;              // R3

		// ------------------------------------------------------------
		// Request-page reads, data one cycle later
		// ------------------------------------------------------------
		if (rd_in && !ctl_sel_in) begin
			if (region_of(addr_in) == REGION_FLAG) begin
				rd = word_of({80'h0, s_q.flag}, first_req(addr_in) / DATA_W);      // R10
			end else if (region_of(addr_in) == REGION_ENABLE) begin
				rd = word_of({80'h0, s_q.enable}, first_req(addr_in) / DATA_W);    // R10
			end else begin
				widx = addr_in - REG_PRIO0;
				for (int k = 0; k < 4; k++) begin
					if (int'(widx)*4 + k < NUM_REQ) begin
						rd[k*4 +: 3] = prio_of(s_q.prio, int'(widx)*4 + k);   // R11
					end
				end
			end
		end

		// ------------------------------------------------------------
		// Control-page reads
		// ------------------------------------------------------------
		if (rd_in && ctl_sel_in) begin
			unique case (addr_in)
				REG_CTL_TRAP: begin
					rd[OSC_FAIL_BIT] = s_q.osc_fail;                        // R1
					rd[GEN_TRAP_BIT] = s_q.addr_err | s_q.stack_err | s_q.math_err; // R2
				end
				REG_CTL_TWO: begin
					rd[ALT_TABLE_BIT] = s_q.alt_table;
					rd[SOFT_HARD_EN]  = s_q.soft_hard_en;
				end
				REG_CTL_HWE: begin
					rd[ECC_DBL_BIT]   = s_q.ecc_dbl;
					rd[SOFT_HARD_BIT] = s_q.soft_hard;
				end
				default: begin
				end
			endcase
		end
		s_d.rdata = rd;

		// ------------------------------------------------------------
		// Request ranking: highest user level, then lowest vector
		// ------------------------------------------------------------
		for (int n = NUM_REQ-1; n >= 0; n--) begin
			if (eff_prio[n] != 3'h0 && eff_prio[n] >= best_p) begin // R14 R17
				best_p = eff_prio[n];
				best_n = 6'(n);
				found = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Trap ranking: fixed order, every trap above every request
		// ------------------------------------------------------------
		hard_pend = s_q.ecc_dbl | (s_q.soft_hard & s_q.soft_hard_en);     // R3 R4
		s_d.irq = 1'b1;
		if (s_q.osc_fail) begin
			s_d.vector = VEC_OSC;                                           // R1
			s_d.level  = PRI_OSC;
		end else if (s_q.addr_err) begin
			s_d.vector = VEC_ADDR;                                          // R2
			s_d.level  = PRI_ADDR;
		end else if (hard_pend) begin
			s_d.vector = VEC_HARD;                                          // R3
			s_d.level  = PRI_HARD;
		end else if (s_q.stack_err) begin
			s_d.vector = VEC_STACK;                                         // R5
			s_d.level  = PRI_STACK;
		end else if (s_q.math_err) begin
			s_d.vector = VEC_MATH;                                          // R6 R7
			s_d.level  = PRI_MATH;
		end else if (found) begin
			s_d.vector = 7'(best_n) + REQ_VEC_OFFSET;                       // R9 R16
			s_d.level  = {1'b0, best_p};
		end else begin
			s_d.irq    = 1'b0;
			s_d.vector = 7'h00;
			s_d.level  = 4'h0;
		end

		// ------------------------------------------------------------
		// Table address
		// ------------------------------------------------------------
		s_d.taddr = table_of(s_d.vector, s_q.alt_table);                  // R8 R15
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.prio <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_out      = s_q.rdata;
	assign irq_out        = s_q.irq;
	assign vector_out     = s_q.vector;
	assign level_out      = s_q.level;
	assign table_addr_out = s_q.taddr;
endmodule

// ### hdl/trap_irq_pkg.sv
// Constants for the trap and peripheral request vector map.
// Assumes a single 125 MHz clock domain and word-wide register port.
package trap_irq_pkg;
	localparam int ADDR_W      = 4;
	localparam int DATA_W      = 16;
	localparam int NUM_REQ     = 40;
	localparam int NUM_TRAP    = 8;
	localparam int VEC_W       = 7;
	localparam int TADDR_W     = 24;
	localparam int PRIO_W      = 4;

	// Register map (word indices)
	localparam logic [ADDR_W-1:0] REG_FLAG0    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_FLAG1    = 4'h1;
	localparam logic [ADDR_W-1:0] REG_FLAG2    = 4'h2;
	localparam logic [ADDR_W-1:0] REG_ENABLE0  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_ENABLE1  = 4'h4;
	localparam logic [ADDR_W-1:0] REG_ENABLE2  = 4'h5;
	localparam logic [ADDR_W-1:0] REG_PRIO0    = 4'h6;
	localparam logic [ADDR_W-1:0] REG_PRIO9    = 4'hf;
	localparam logic [ADDR_W-1:0] REG_TRAPSTAT = 4'h4;
	// Control registers live in a second page selected by ctl_sel_in
	localparam logic [ADDR_W-1:0] REG_CTL_TRAP = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CTL_TWO  = 4'h1;
	localparam logic [ADDR_W-1:0] REG_CTL_HWE  = 4'h2;

	// Field positions
	localparam int OSC_FAIL_BIT   = 1;
	localparam int GEN_TRAP_BIT   = 3;
	localparam int ECC_DBL_BIT    = 1;
	localparam int SOFT_HARD_BIT  = 0;
	localparam int SOFT_HARD_EN   = 13;
	localparam int ALT_TABLE_BIT  = 8;

	// Trap vectors and fixed priorities
	localparam logic [VEC_W-1:0]  VEC_OSC   = 7'h00;
	localparam logic [VEC_W-1:0]  VEC_ADDR  = 7'h01;
	localparam logic [VEC_W-1:0]  VEC_HARD  = 7'h02;
	localparam logic [VEC_W-1:0]  VEC_STACK = 7'h03;
	localparam logic [VEC_W-1:0]  VEC_MATH  = 7'h04;
	localparam logic [PRIO_W-1:0] PRI_OSC   = 4'hf;
	localparam logic [PRIO_W-1:0] PRI_ADDR  = 4'he;
	localparam logic [PRIO_W-1:0] PRI_HARD  = 4'hd;
	localparam logic [PRIO_W-1:0] PRI_STACK = 4'hc;
	localparam logic [PRIO_W-1:0] PRI_MATH  = 4'hb;
	localparam logic [VEC_W-1:0]  REQ_VEC_OFFSET = 7'h08;

	// Table addresses: trap 0 sits at 000004h, request 0 at 000014h
	localparam logic [TADDR_W-1:0] TABLE_TRAP_BASE = 24'h000004;
	localparam logic [TADDR_W-1:0] TABLE_REQ_BASE  = 24'h000014;
	localparam logic [TADDR_W-1:0] ALT_LOW_BASE    = 24'h000004;

	// Requests with no flag, enable or priority field
	localparam logic [NUM_REQ-1:0] REQ_RESERVED = 40'hcc_1ce0_0000;
	localparam logic [DATA_W-1:0]  RST_WORD     = 16'h0000;
	localparam logic [DATA_W-1:0]  PRIO_RST     = 16'h4444;
endpackage
